// *** rtl/vxit_regs.svh ***
/*
 * constants of the guest-exit detail generator: field positions, cause codes,
 * register offsets of the axi4-lite slave, interrupt bits.
 * assumes inclusion by its bare name from the package and the design module.
 */
`ifndef VXIT_REGS_SVH
`define VXIT_REGS_SVH

// ==========================================================================
// cause codes and cluster/target limits of an incomplete delivery
`define VXIT_CAUSE_BAD_TYPE    32'h0000_0000
`define VXIT_CAUSE_NOT_SCHED   32'h0000_0001
`define VXIT_CAUSE_BAD_TARGET  32'h0000_0002
`define VXIT_CAUSE_BAD_PAGE    32'h0000_0003
`define VXIT_MAX_CLUSTER       16'h0040
`define VXIT_MAX_PHYSICAL      16'h0200

// ==========================================================================
// detail word fields
`define VXIT_RW_BIT            32
`define VXIT_OFS_HI            11
`define VXIT_OFS_LO            4
`define VXIT_EOI_OFFSET        12'h0b0

// ==========================================================================
// register byte offsets
`define VXIT_ADDR_STATUS       8'h00
`define VXIT_ADDR_MASK         8'h04
`define VXIT_ADDR_CODE         8'h08
`define VXIT_ADDR_D1_LO        8'h0c
`define VXIT_ADDR_D1_HI        8'h10
`define VXIT_ADDR_D2_LO        8'h14
`define VXIT_ADDR_D2_HI        8'h18
`define VXIT_ADDR_PENDING      8'h1c

// ==========================================================================
// status and mask bits
`define VXIT_IRQ_IPI           0
`define VXIT_IRQ_NOACC         1
`define VXIT_IRQ_LOST          2
`define VXIT_IRQ_W             3

// ==========================================================================
// axi responses
`define VXIT_RESP_OKAY         2'b00
`define VXIT_RESP_SLVERR       2'b10

`endif

// *** rtl/vxit_pkg.sv ***
/*
 * types of the guest-exit detail generator.
 * assumes vxit_regs.svh is on the include path.
 */
package vxit_pkg;
`include "vxit_regs.svh"

   typedef enum logic [1:0] {
      VXIT_FAIL_NONE,
      VXIT_FAIL_NOT_SCHED,
      VXIT_FAIL_BAD_TARGET,
      VXIT_FAIL_BAD_PAGE
   } vxit_fail_t;

   typedef enum logic [1:0] {
      VXIT_WR_IDLE,
      VXIT_WR_RESP
   } vxit_wr_t;

endpackage : vxit_pkg

// *** rtl/vxit_exit_gen.sv ***
/*
 * guest-exit generator: turns an incomplete interrupt delivery or an
 * unaccelerated controller-page access into an exit code and two 64-bit
 * detail words, held until the next exit, readable over axi4-lite.
 * assumes the delivery walk and the access filter live elsewhere and
 * report one-cycle events on the core clock.
 */
`include "vxit_regs.svh"

// Summary of operation
// - undeliverable interrupt to unscheduled target raises delivery-incomplete exit
// - delivery exit detail one holds command high over command low
// - delivery exit detail two holds cause in 63:32, bits 31:8 zero
// - causes one to three carry the table index in bits 7:0
// - level trigger or bad destination type gives cause zero, no index
// - target not scheduled gives cause one with that target's index
// - logical cluster over 64, physical target over 512 or absent entry gives cause two
// - bad backing page pointer gives cause three with table index
// - unhandled controller page access raises unaccelerated-access exit
// - end of interrupt with level in-service interrupt also raises that exit
// - detail one bit 32 marks write, bits 63:33 zero
// - offset bits 11:4 sit in detail one bits 11:4, rest zero
// - write to offset b0 puts in-service vector in detail two 7:0
module vxit_exit_gen
   import vxit_pkg::*;
#(
   parameter logic [31:0] IPI_INCOMPLETE_CODE = 32'h0000_0001,  // arbitrary
   parameter logic [31:0] NOACCEL_CODE        = 32'h0000_0002   // arbitrary
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // delivery failure report
   input  wire logic        ipi_fail_valid,
   input  wire logic        ipi_level_trigger,
   input  wire logic        ipi_bad_dest_type,
   input  wire vxit_fail_t  ipi_fail_kind,
   input  wire logic [15:0] ipi_cluster,
   input  wire logic [15:0] ipi_target,
   input  wire logic        ipi_logical_mode,
   input  wire logic [7:0]  ipi_index,
   input  wire logic [31:0] command_register_high,
   input  wire logic [31:0] command_register_low,
   // unaccelerated access report
   input  wire logic        acc_valid,
   input  wire logic        acc_write,
   input  wire logic [11:0] register_offset,
   input  wire logic        eoi_level_valid,
   input  wire logic [7:0]  in_service_vector,
   // exit output
   output logic             guest_exit,
   output logic [31:0]      exit_code,
   output logic [63:0]      exit_detail_one,
   output logic [63:0]      exit_detail_two,
   output logic             irq,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // =======================================================================
   // cause selection for an incomplete delivery
   logic        over_limit;
   logic [31:0] ipi_cause;
   logic        ipi_has_index;
   logic        ipi_event;
   logic        acc_event;

   always_comb begin
      over_limit = ipi_logical_mode ? (ipi_cluster > `VXIT_MAX_CLUSTER)
                                    : (ipi_target  > `VXIT_MAX_PHYSICAL);
      ipi_has_index = 1'b1;
      if (ipi_level_trigger || ipi_bad_dest_type) begin
         ipi_cause     = `VXIT_CAUSE_BAD_TYPE;
         ipi_has_index = 1'b0;
      end else if (over_limit || ipi_fail_kind == VXIT_FAIL_BAD_TARGET) begin
         ipi_cause     = `VXIT_CAUSE_BAD_TARGET;
      end else if (ipi_fail_kind == VXIT_FAIL_BAD_PAGE) begin
         ipi_cause     = `VXIT_CAUSE_BAD_PAGE;
      end else begin
         ipi_cause     = `VXIT_CAUSE_NOT_SCHED;
      end
   end

   // a report of no failure and no bad type/limit is not an exit
   assign ipi_event = ipi_fail_valid &&
                      (ipi_level_trigger || ipi_bad_dest_type || over_limit ||
                       ipi_fail_kind != VXIT_FAIL_NONE);
   assign acc_event = acc_valid || eoi_level_valid;

   // =======================================================================
   // detail words; delivery wins when both arrive together
   logic        nxt_exit;
   logic [31:0] nxt_code;
   logic [63:0] nxt_d1;
   logic [63:0] nxt_d2;
   logic        eoi_write;
   localparam logic [11:0] EOI_OFS = `VXIT_EOI_OFFSET;

   always_comb begin
      eoi_write = eoi_level_valid ||
                  (acc_write && register_offset == `VXIT_EOI_OFFSET);
      nxt_exit  = ipi_event || acc_event;
      nxt_code  = 32'h0000_0000;
      nxt_d1    = 64'h0000_0000_0000_0000;
      nxt_d2    = 64'h0000_0000_0000_0000;
      if (ipi_event) begin
         nxt_code = IPI_INCOMPLETE_CODE;
         nxt_d1   = {command_register_high, command_register_low};
         nxt_d2[63:32] = ipi_cause;
         if (ipi_has_index) begin
            nxt_d2[7:0] = ipi_index;
         end
      end else if (acc_event) begin
         nxt_code = NOACCEL_CODE;
         nxt_d1[`VXIT_RW_BIT] = acc_write || eoi_level_valid;
         nxt_d1[`VXIT_OFS_HI:`VXIT_OFS_LO] = eoi_level_valid
            ? EOI_OFS[`VXIT_OFS_HI:`VXIT_OFS_LO]
            : register_offset[`VXIT_OFS_HI:`VXIT_OFS_LO];
         if (eoi_write) begin
            nxt_d2[7:0] = in_service_vector;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         guest_exit      <= 1'b0;
         exit_code       <= 32'h0000_0000;
         exit_detail_one <= 64'h0000_0000_0000_0000;
         exit_detail_two <= 64'h0000_0000_0000_0000;
      end else begin
         guest_exit <= nxt_exit;
         if (nxt_exit) begin
            exit_code       <= nxt_code;
            exit_detail_one <= nxt_d1;
            exit_detail_two <= nxt_d2;
         end
      end
   end

   // =======================================================================
   // status, mask and interrupt
   logic [`VXIT_IRQ_W-1:0] status_ff;
   logic [`VXIT_IRQ_W-1:0] mask_ff;
   logic [`VXIT_IRQ_W-1:0] set_bits;
   logic [`VXIT_IRQ_W-1:0] clr_bits;
   logic                   wr_fire;
   logic [7:0]             aw_ff;
   logic [31:0]            w_ff;
   logic                   aw_have_ff;
   logic                   w_have_ff;

   // lost: a new exit while the previous one is still flagged
   assign set_bits = {(nxt_exit && |status_ff[1:0]), acc_event && !ipi_event, ipi_event};
   assign clr_bits = (wr_fire && aw_ff == `VXIT_ADDR_STATUS)
                     ? w_ff[`VXIT_IRQ_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= '0;
      end else begin
         status_ff <= (status_ff & ~clr_bits) | set_bits;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_ff <= '0;
      end else if (wr_fire && aw_ff == `VXIT_ADDR_MASK) begin
         mask_ff <= w_ff[`VXIT_IRQ_W-1:0];
      end
   end

   assign irq = |(status_ff & mask_ff);

   // =======================================================================
   // axi4-lite write channel
   vxit_wr_t wr_state_ff;

   assign s_axi_awready = !aw_have_ff && wr_state_ff == VXIT_WR_IDLE;
   assign s_axi_wready  = !w_have_ff && wr_state_ff == VXIT_WR_IDLE;
   assign wr_fire       = aw_have_ff && w_have_ff && wr_state_ff == VXIT_WR_IDLE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         aw_ff      <= 8'h00;
         w_ff       <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            aw_ff      <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_fire) begin
            aw_have_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            // partial strobes zero the lanes they do not enable; the whole word is then written
            w_ff      <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end else if (wr_fire) begin
            w_have_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_ff  <= VXIT_WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `VXIT_RESP_OKAY;
      end else begin
         unique case (wr_state_ff)
            VXIT_WR_IDLE: begin
               if (wr_fire) begin
                  wr_state_ff  <= VXIT_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= (aw_ff == `VXIT_ADDR_STATUS || aw_ff == `VXIT_ADDR_MASK)
                                  ? `VXIT_RESP_OKAY : `VXIT_RESP_SLVERR;
               end
            end
            VXIT_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_ff  <= VXIT_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
         endcase
      end
   end

   // =======================================================================
   // axi4-lite read channel
   logic [31:0] rd_data;
   logic        rd_ok;

   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
         `VXIT_ADDR_STATUS:  rd_data[`VXIT_IRQ_W-1:0] = status_ff;
         `VXIT_ADDR_MASK:    rd_data[`VXIT_IRQ_W-1:0] = mask_ff;
         `VXIT_ADDR_CODE:    rd_data = exit_code;
         `VXIT_ADDR_D1_LO:   rd_data = exit_detail_one[31:0];
         `VXIT_ADDR_D1_HI:   rd_data = exit_detail_one[63:32];
         `VXIT_ADDR_D2_LO:   rd_data = exit_detail_two[31:0];
         `VXIT_ADDR_D2_HI:   rd_data = exit_detail_two[63:32];
         `VXIT_ADDR_PENDING: rd_data[0] = irq;
         default:            rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `VXIT_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_ok ? `VXIT_RESP_OKAY : `VXIT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // =======================================================================
   // checks
   property p_ipi_code;
      @(posedge aclk) disable iff (!aresetn)
      ipi_event |=> guest_exit && exit_code == IPI_INCOMPLETE_CODE;
   endproperty
   a_ipi_code: assert property (p_ipi_code) else $error("delivery exit code wrong");

   property p_cmd_words;
      @(posedge aclk) disable iff (!aresetn)
      ipi_event |=> exit_detail_one == {$past(command_register_high),
                                        $past(command_register_low)};
   endproperty
   a_cmd_words: assert property (p_cmd_words) else $error("command words not kept");

   property p_ipi_reserved;
      @(posedge aclk) disable iff (!aresetn)
      guest_exit && exit_code == IPI_INCOMPLETE_CODE |-> exit_detail_two[31:8] == 24'h0;
   endproperty
   a_ipi_reserved: assert property (p_ipi_reserved) else $error("reserved bits set");

   property p_type_no_index;
      @(posedge aclk) disable iff (!aresetn)
      ipi_fail_valid && ipi_level_trigger |=>
         exit_detail_two == 64'h0000_0000_0000_0000;
   endproperty
   a_type_no_index: assert property (p_type_no_index) else $error("cause zero wrong");

   property p_index;
      @(posedge aclk) disable iff (!aresetn)
      ipi_event && ipi_cause != `VXIT_CAUSE_BAD_TYPE |=>
         exit_detail_two[7:0] == $past(ipi_index);
   endproperty
   a_index: assert property (p_index) else $error("table index lost");

   property p_limit;
      @(posedge aclk) disable iff (!aresetn)
      ipi_fail_valid && !ipi_level_trigger && !ipi_bad_dest_type &&
      !ipi_logical_mode && ipi_target > `VXIT_MAX_PHYSICAL |=>
         exit_detail_two[63:32] == `VXIT_CAUSE_BAD_TARGET;
   endproperty
   a_limit: assert property (p_limit) else $error("target limit not flagged");

   property p_rw_bit;
      @(posedge aclk) disable iff (!aresetn)
      acc_valid && !ipi_event && !eoi_level_valid |=>
         exit_code == NOACCEL_CODE && exit_detail_one[32] == $past(acc_write) &&
         exit_detail_one[63:33] == 31'h0;
   endproperty
   a_rw_bit: assert property (p_rw_bit) else $error("direction bit wrong");

   property p_offset;
      @(posedge aclk) disable iff (!aresetn)
      acc_valid && !ipi_event && !eoi_level_valid |=>
         exit_detail_one[11:4] == $past(register_offset[11:4]) &&
         exit_detail_one[31:12] == 20'h0 && exit_detail_one[3:0] == 4'h0;
   endproperty
   a_offset: assert property (p_offset) else $error("offset field wrong");

   property p_not_sched;
      @(posedge aclk) disable iff (!aresetn)
      ipi_fail_valid && !ipi_level_trigger && !ipi_bad_dest_type && !over_limit &&
      ipi_fail_kind == VXIT_FAIL_NOT_SCHED |=>
         exit_detail_two[63:32] == `VXIT_CAUSE_NOT_SCHED;
   endproperty
   a_not_sched: assert property (p_not_sched) else $error("cause one wrong");

   property p_bad_page;
      @(posedge aclk) disable iff (!aresetn)
      ipi_fail_valid && !ipi_level_trigger && !ipi_bad_dest_type && !over_limit &&
      ipi_fail_kind == VXIT_FAIL_BAD_PAGE |=>
         exit_detail_two[63:32] == `VXIT_CAUSE_BAD_PAGE &&
         exit_detail_two[7:0] == $past(ipi_index);
   endproperty
   a_bad_page: assert property (p_bad_page) else $error("cause three wrong");

   property p_cluster;
      @(posedge aclk) disable iff (!aresetn)
      ipi_fail_valid && !ipi_level_trigger && !ipi_bad_dest_type &&
      ipi_logical_mode && ipi_cluster > `VXIT_MAX_CLUSTER |=>
         exit_detail_two[63:32] == `VXIT_CAUSE_BAD_TARGET;
   endproperty
   a_cluster: assert property (p_cluster) else $error("cluster limit not flagged");

   property p_eoi_reg;
      @(posedge aclk) disable iff (!aresetn)
      acc_valid && acc_write && register_offset == `VXIT_EOI_OFFSET &&
      !ipi_event && !eoi_level_valid |=>
         exit_detail_two[7:0] == $past(in_service_vector);
   endproperty
   a_eoi_reg: assert property (p_eoi_reg) else $error("eoi write vector lost");

   property p_eoi_vec;
      @(posedge aclk) disable iff (!aresetn)
      eoi_level_valid && !ipi_event |=>
         exit_code == NOACCEL_CODE && exit_detail_two[7:0] == $past(in_service_vector);
   endproperty
   a_eoi_vec: assert property (p_eoi_vec) else $error("eoi vector lost");

endmodule : vxit_exit_gen

// *** tb/vxit_exit_gen_bench.sv ***
/*
 * self-checking bench of the guest-exit generator: a queue model of the exit
 * outputs, register checks over axi4-lite.
 * assumes vxit_pkg and vxit_exit_gen are compiled before it.
 */
`include "vxit_regs.svh"

module vxit_exit_gen_bench import vxit_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] CODE_IPI   = 32'h0000_00a5;  // arbitrary
   localparam logic [31:0] CODE_NOACC = 32'h0000_005a;  // arbitrary

   typedef struct {logic ex; logic [31:0] code; logic [63:0] d1; logic [63:0] d2;} vxit_exp_t;

   // =====================================================================
   // design inputs and outputs
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic        ipi_fail_valid = 1'b0, ipi_level_trigger = 1'b0, ipi_bad_dest_type = 1'b0;
   vxit_fail_t  ipi_fail_kind = VXIT_FAIL_NONE;
   logic [15:0] ipi_cluster = 16'h0000, ipi_target = 16'h0000;
   logic        ipi_logical_mode = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
   logic        eoi_level_valid = 1'b0;
   logic [7:0]  ipi_index = 8'h00, in_service_vector = 8'h00;
   logic [11:0] register_offset = 12'h000;
   logic [31:0] command_register_high = 32'h0, command_register_low = 32'h0;
   logic        guest_exit, irq;
   logic [31:0] exit_code;
   logic [63:0] exit_detail_one, exit_detail_two;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;

   // model state
   vxit_exp_t   q[$];
   vxit_exp_t   last, si, sa;
   bit          pi, pa, rq_ipi, rq_acc, rq_eoi;
   int          st, msk, n_fail, samples_checked, cyc;

   vxit_exit_gen #(.IPI_INCOMPLETE_CODE(CODE_IPI), .NOACCEL_CODE(CODE_NOACC)) u_vxit_exit_gen (
      .aclk, .aresetn, .ipi_fail_valid, .ipi_level_trigger, .ipi_bad_dest_type,
      .ipi_fail_kind, .ipi_cluster, .ipi_target, .ipi_logical_mode, .ipi_index,
      .command_register_high, .command_register_low, .acc_valid, .acc_write,
      .register_offset, .eoi_level_valid, .in_service_vector, .guest_exit, .exit_code,
      .exit_detail_one, .exit_detail_two, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always #12.5 aclk = ~aclk;

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   // =====================================================================
   // compare and report
   task automatic chk(input logic [63:0] got, input logic [63:0] want);
      samples_checked++;
      if (got !== want) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   // =====================================================================
   // event drivers and model
   task automatic tick();
      @(posedge aclk);
      ipi_fail_valid <= rq_ipi;
      acc_valid <= rq_acc;
      eoi_level_valid <= rq_eoi;
      rq_ipi = 1'b0;
      rq_acc = 1'b0;
      rq_eoi = 1'b0;
   endtask : tick

   task automatic set_ipi(input logic lvl, bad, input int k, input logic lg,
                          input logic [15:0] cl, tg, input logic [7:0] ix);
      int c;
      logic [31:0] hi, lo;
      hi = $urandom;
      lo = $urandom;
      rq_ipi = 1'b1;
      ipi_level_trigger <= lvl;
      ipi_bad_dest_type <= bad;
      ipi_fail_kind <= vxit_fail_t'(k[1:0]);
      ipi_logical_mode <= lg;
      ipi_cluster <= cl;
      ipi_target <= tg;
      ipi_index <= ix;
      command_register_high <= hi;
      command_register_low <= lo;
      c = (lvl || bad) ? 0 : (k == 2 || (lg && cl > 64) || (!lg && tg > 512)) ? 2 :
          (k == 3) ? 3 : (k == 1) ? 1 : -1;
      pi = (c >= 0);
      si = '{1'b1, CODE_IPI, {hi, lo}, {c[31:0], 24'h0, (c > 0) ? ix : 8'h00}};
   endtask : set_ipi

   task automatic set_acc(input logic w, input logic [11:0] ofs, input logic [7:0] vec);
      rq_acc = 1'b1;
      acc_write <= w;
      register_offset <= ofs;
      in_service_vector <= vec;
      pa = 1'b1;
      sa = '{1'b1, CODE_NOACC, {31'h0, w, 20'h0, ofs[11:4], 4'h0},
             {56'h0, (w && ofs[11:4] == 8'h0b) ? vec : 8'h00}};
   endtask : set_acc

   task automatic set_eoi(input logic [7:0] vec);
      rq_eoi = 1'b1;
      in_service_vector <= vec;
      pa = 1'b1;
      sa = '{1'b1, CODE_NOACC, {31'h0, 1'b1, 20'h0, 8'h0b, 4'h0}, {56'h0, vec}};
   endtask : set_eoi

   task automatic launch();
      vxit_exp_t e;
      e = pi ? si : pa ? sa : '{1'b0, last.code, last.d1, last.d2};
      if (e.ex) begin
         if (st[1:0] != 0) st |= 4;
         st |= pi ? 1 : 2;
         last = e;
      end
      q.push_back(e);
      pi = 1'b0;
      pa = 1'b0;
   endtask : launch

   task automatic take();
      vxit_exp_t e;
      e = q.pop_front();
      #1;
      chk(guest_exit, e.ex);
      chk(exit_code, e.code);
      chk(exit_detail_one, e.d1);
      chk(exit_detail_two, e.d2);
   endtask : take

   // =====================================================================
   // register bus master
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want, input logic [1:0] rw);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      chk(s_axi_rdata, want);
      chk(s_axi_rresp, rw);
      s_axi_rready <= 1'b0;
   endtask : rd_chk

   task automatic check_regs();
      logic [7:0]  ad[5];
      logic [31:0] ev[5];
      logic [1:0]  r;
      ad = '{`VXIT_ADDR_CODE, `VXIT_ADDR_D1_LO, `VXIT_ADDR_D1_HI, `VXIT_ADDR_D2_LO,
             `VXIT_ADDR_D2_HI};
      ev = '{last.code, last.d1[31:0], last.d1[63:32], last.d2[31:0], last.d2[63:32]};
      rd_chk(`VXIT_ADDR_STATUS, st, 2'b00);
      for (int i = 0; i < 5; i++) rd_chk(ad[i], ev[i], 2'b00);
      chk(irq, (st & msk) != 0);
      rd_chk(`VXIT_ADDR_PENDING, 32'((st & msk) != 0), 2'b00);
      axi_wr(`VXIT_ADDR_STATUS, 32'h7, r);
      st = 0;
      chk(r, 2'b00);
      chk(irq, 1'b0);
   endtask : check_regs

   // =====================================================================
   // main sequence
   initial begin
      logic [1:0]  r;
      logic [31:0] m;
      logic [11:0] ofs;
      int          sel;
      void'($urandom(99567));
      last = '{1'b0, 32'h0, 64'h0, 64'h0};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk(guest_exit, 1'b0);
      chk(exit_code, 32'h0);
      chk(s_axi_awready, 1'b1);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 6; j++) begin
            set_ipi(j == 4, j == 5, k, j[0], 16'(63 + j), 16'(511 + j), 8'($urandom));
            launch();
            tick();
            tick();
            take();
            check_regs();
         end
      end
      $display("test cause table done");
      for (int i = 0; i < 60; i++) begin
         m = 32'($urandom_range(0, 7));
         axi_wr(`VXIT_ADDR_MASK, m, r);
         msk = m;
         rd_chk(`VXIT_ADDR_MASK, m, 2'b00);
         sel = $urandom_range(0, 3);
         ofs = ($urandom_range(0, 3) == 0) ? 12'h0b0 : 12'($urandom);
         if (ofs[11:4] == 8'h0b) ofs[3:0] = 4'h0;
         if (sel != 1) set_ipi($urandom_range(0, 7) == 0, $urandom_range(0, 7) == 0,
                               $urandom_range(0, 3), 1'($urandom), 16'(60 + $urandom_range(0, 7)),
                               16'(508 + $urandom_range(0, 7)), 8'($urandom));
         if (sel == 1 || sel == 3) set_acc(1'($urandom), ofs, 8'($urandom));
         if (sel == 2) set_eoi(8'($urandom));
         launch();
         tick();
         tick();
         take();
         check_regs();
      end
      $display("test random mix done");
      set_ipi(1'b0, 1'b0, 1, 1'b0, 16'd1, 16'd1, 8'h2c);
      launch();
      tick();
      set_acc(1'b0, 12'h300, 8'h00);
      launch();
      tick();
      take();
      tick();
      take();
      rd_chk(`VXIT_ADDR_STATUS, 32'h7, 2'b00);
      axi_wr(`VXIT_ADDR_STATUS, 32'h2, r);
      st = 5;
      check_regs();
      $display("test back to back done");
      rd_chk(8'h20, 32'h0, 2'b10);
      axi_wr(`VXIT_ADDR_CODE, 32'hffff_ffff, r);
      chk(r, 2'b10);
      check_regs();
      $display("test refusals done");
      print_verdict();
   end
endmodule : vxit_exit_gen_bench
